/* logic/cebc_pkg.sv */
// constants and carrier types for the channel enable and breaker block
package cebc_pkg;
    // register offsets on the serial register port
    localparam logic [7:0] CEBC_ADDR_RATIO = 8'h30;
    localparam logic [7:0] CEBC_ADDR_STATUS = 8'h32;
    localparam logic [7:0] CEBC_ADDR_ENABLE = 8'h3B;
    // reset values
    localparam logic [3:0] CEBC_RATIO_RESET = 4'hF;
    localparam logic [3:0] CEBC_ENABLE_RESET = 4'h0;
    localparam logic [7:0] CEBC_READ_ZERO = 8'h00;
    // field positions
    localparam int CEBC_EN_A_BIT = 0;
    localparam int CEBC_EN_B_BIT = 1;
    localparam int CEBC_ON_BIT = 0;
    localparam int CEBC_PROT_LSB = 6;
    localparam int CEBC_PROT_MSB = 7;
    // protection behaviour codes
    localparam logic [1:0] CEBC_PROT_ALERT = 2'h0;
    localparam logic [1:0] CEBC_PROT_PG = 2'h1;
    localparam logic [1:0] CEBC_PROT_SHUT = 2'h2;
    localparam logic [1:0] CEBC_PROT_NONE = 2'h3;
    // current-sense range codes and full scale, sense units of 0.1 mV
    localparam logic [1:0] CEBC_RNG_25 = 2'h2;
    localparam logic [1:0] CEBC_RNG_50 = 2'h1;
    localparam logic [1:0] CEBC_RNG_100 = 2'h0;
    localparam logic [11:0] CEBC_FS_25 = 12'h0FA;
    localparam logic [11:0] CEBC_FS_50 = 12'h1F4;
    localparam logic [11:0] CEBC_FS_100 = 12'h3E8;
    // fast threshold = fs * (LO_NUM*DAC_MAX + SPAN_NUM*dac) / (DEN*DAC_MAX): 40..100 %
    localparam logic [21:0] CEBC_DAC_MAX = 22'h0000FF;
    localparam logic [21:0] CEBC_LO_NUM = 22'h000002;
    localparam logic [21:0] CEBC_SPAN_NUM = 22'h000003;
    localparam logic [21:0] CEBC_DEN = 22'h000005;
    // fast-to-slow ratios in percent
    localparam logic [17:0] CEBC_PCT_UNIT = 18'h00064;
    localparam logic [17:0] CEBC_PCT_125 = 18'h0007D;
    localparam logic [17:0] CEBC_PCT_150 = 18'h00096;
    localparam logic [17:0] CEBC_PCT_175 = 18'h000AF;
    localparam logic [17:0] CEBC_PCT_200 = 18'h000C8;
    // slow-trip overdrive budget and leak, in 0.1 mV x cycles
    localparam logic [19:0] CEBC_SLOW_BUDGET = 20'h03E80;
    localparam logic [19:0] CEBC_SLOW_LEAK = 20'h00004;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } cebc_wr_type;

    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic warning;
    } cebc_volt_type;
endpackage : cebc_pkg

/* logic/cebc_trip_eval.sv */
// fast-trip and slow-trip circuit-breaker comparators
`timescale 1ns/1ps
module cebc_trip_eval import cebc_pkg::*; #(
    parameter logic [19:0] SLOW_BUDGET = CEBC_SLOW_BUDGET
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // settings
    input wire logic [7:0] dac_setting,
    input wire logic [1:0] range_sel,
    input wire logic [1:0] ratio_sel,
    // sensed current, 0.1 mV units
    input wire logic [11:0] sense_level,
    // trip results
    output logic trip_fast_q,
    output logic trip_slow_q
);
    logic [11:0] fs;
    logic [21:0] fast_wide;
    logic [11:0] fast_thr;
    logic [17:0] slow_wide;
    logic [11:0] slow_thr;
    logic [19:0] acc_q;
    logic [19:0] acc_d;
    logic [20:0] acc_sum;
    logic trip_fast_d;
    logic trip_slow_d;

    function automatic logic [17:0] ratio_pct(input logic [1:0] code);
        case (code)
            2'h0: ratio_pct = CEBC_PCT_125;
            2'h1: ratio_pct = CEBC_PCT_150;
            2'h2: ratio_pct = CEBC_PCT_175;
            default: ratio_pct = CEBC_PCT_200;
        endcase
    endfunction : ratio_pct

    always_comb begin
        case (range_sel) // see [R9]
            CEBC_RNG_25: fs = CEBC_FS_25;
            CEBC_RNG_50: fs = CEBC_FS_50;
            default: fs = CEBC_FS_100;
        endcase
        fast_wide = (22'(fs) * (CEBC_LO_NUM * CEBC_DAC_MAX + CEBC_SPAN_NUM * 22'(dac_setting)))
            / (CEBC_DEN * CEBC_DAC_MAX); // see [R8]
        fast_thr = fast_wide[11:0];
        slow_wide = (18'(fast_thr) * CEBC_PCT_UNIT) / ratio_pct(ratio_sel); // see [R10] [R13]
        slow_thr = slow_wide[11:0];
        // overdrive integrates, so a small brief excess leaks away before tripping
        acc_sum = 21'(acc_q) + 21'(sense_level - slow_thr);
        if (sense_level > slow_thr) begin // see [R12]
            acc_d = acc_sum[20] ? 20'hFFFFF : acc_sum[19:0];
        end else if (acc_q > CEBC_SLOW_LEAK) begin
            acc_d = acc_q - CEBC_SLOW_LEAK;
        end else begin
            acc_d = 20'h00000;
        end
        trip_slow_d = acc_d >= SLOW_BUDGET; // see [R12]
        trip_fast_d = sense_level > fast_thr; // see [R7]
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= 20'h00000;
            trip_fast_q <= 1'b0;
            trip_slow_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            trip_fast_q <= trip_fast_d;
            trip_slow_q <= trip_slow_d;
        end
    end

    fast_above_slow_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R10]
        fast_thr > slow_thr || fast_thr == 12'h000)
        else $error("fast threshold not above slow threshold");
    fast_floor_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R8]
        22'(fast_thr) * CEBC_DEN >= 22'(fs) * CEBC_LO_NUM - CEBC_DEN && fast_thr <= fs)
        else $error("fast threshold outside 40 to 100 percent");
    big_trip_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R7]
        sense_level > fast_thr |=> trip_fast_q)
        else $error("fast trip missed");
endmodule : cebc_trip_eval

/* logic/cebc_channel_ctrl.sv */
// register bank and on-off control for one hot-swap channel
//
// Function
// [R1] enable register: two writable enable bits
// [R2] status bit 0 shows on-input comparator
// [R3] protection 00: critical only raises alert
// [R4] protection 01: alert and power-good low
// [R5] protection 10: alert, power-good low, shutdown
// [R6] status register read-only, strap and on-input
// [R7] either threshold exceeded turns switch off
// [R8] fast threshold 40 to 100 percent
// [R9] three full-scale current-sense ranges
// [R10] slow threshold follows fast by ratio
// [R11] ratio register two-bit field, reset 0x0F
// [R12] slow-trip delay shrinks with overdrive
// [R13] ratio codes give 125 to 200 percent
// [R14] read-only bits ignore writes, read zero
`timescale 1ns/1ps
module cebc_channel_ctrl import cebc_pkg::*; #(
    parameter logic [19:0] SLOW_BUDGET = CEBC_SLOW_BUDGET
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register port from the serial interface
    input wire logic wr_en,
    input wire cebc_wr_type wr_req,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_q,
    // pins and analog comparators, asynchronous
    input wire logic on_above_thr,
    input wire logic [1:0] prot_strap,
    input wire cebc_volt_type volt_crit,
    input wire cebc_volt_type volt_warn,
    input wire logic volt_ok,
    // threshold settings and sensed current, same clock
    input wire logic [7:0] dac_setting,
    input wire logic [1:0] range_sel,
    input wire logic [11:0] sense_level,
    // channel outputs
    output logic gate_on_q,
    output logic power_good_output_q,
    output logic alert_q,
    output logic fault_q
);
    logic [1:0] on_sync_q;
    logic [1:0] crit_sync_q;
    logic [1:0] warn_sync_q;
    logic [1:0] ok_sync_q;
    logic [1:0] prot_q;
    logic [1:0] prot_d;
    logic strap_taken_q;
    logic [3:0] strap_sync_q;
    logic [1:0] strap_age_q;
    logic [3:0] ratio_q;
    logic [3:0] ratio_d;
    logic [3:0] enable_q;
    logic [3:0] enable_d;
    logic [7:0] rd_data_d;
    logic latched_off_q;
    logic latched_off_d;
    logic gate_on_d;
    logic pg_d;
    logic alert_d;
    logic crit;
    logic trip_fast;
    logic trip_slow;
    logic channel_enable_a;
    logic channel_enable_b;

    assign crit = crit_sync_q[1];
    assign channel_enable_a = enable_q[CEBC_EN_A_BIT];
    assign channel_enable_b = enable_q[CEBC_EN_B_BIT];

    cebc_trip_eval #(.SLOW_BUDGET(SLOW_BUDGET)) u_trip (
        .clock(clock),
        .rst_b(rst_b),
        .dac_setting(dac_setting),
        .range_sel(range_sel),
        .ratio_sel(ratio_q[1:0]),
        .sense_level(sense_level),
        .trip_fast_q(trip_fast),
        .trip_slow_q(trip_slow)
    );

    // pin synchronisers; first stage read only by the second
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            on_sync_q <= 2'h0;
            crit_sync_q <= 2'h0;
            warn_sync_q <= 2'h0;
            ok_sync_q <= 2'h0;
            strap_sync_q <= 4'h0;
            strap_age_q <= 2'h0;
        end else begin
            on_sync_q <= {on_sync_q[0], on_above_thr};
            strap_sync_q <= {strap_sync_q[1:0], prot_strap};
            strap_age_q <= {strap_age_q[0], 1'b1};
            crit_sync_q <= {crit_sync_q[0], volt_crit.undervoltage | volt_crit.overvoltage};
            warn_sync_q <= {warn_sync_q[0], |volt_warn};
            ok_sync_q <= {ok_sync_q[0], volt_ok};
        end
    end

    // register bank
    always_comb begin
        ratio_d = ratio_q;
        enable_d = enable_q;
        prot_d = prot_q;
        rd_data_d = rd_data_q;
        // strap is static; caught once it has crossed both flops, code 11 cannot occur
        if (!strap_taken_q) begin
            prot_d = (strap_sync_q[3:2] == CEBC_PROT_NONE) ? CEBC_PROT_SHUT
                : strap_sync_q[3:2]; // see [R5]
        end
        // status offset and upper nibbles have no storage, writes fall away
        if (wr_en && wr_req.addr == CEBC_ADDR_RATIO) begin
            ratio_d = wr_req.data[3:0]; // see [R11] [R14]
        end
        if (wr_en && wr_req.addr == CEBC_ADDR_ENABLE) begin
            enable_d = wr_req.data[3:0]; // see [R1] [R14]
        end
        if (rd_en) begin
            case (rd_addr)
                CEBC_ADDR_RATIO: rd_data_d = {4'h0, ratio_q}; // see [R11]
                CEBC_ADDR_STATUS: rd_data_d = {prot_q, 5'h00, on_sync_q[1]}; // see [R2] [R6]
                CEBC_ADDR_ENABLE: rd_data_d = {4'h0, enable_q}; // see [R1]
                default: rd_data_d = CEBC_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ratio_q <= CEBC_RATIO_RESET;
            enable_q <= CEBC_ENABLE_RESET;
            prot_q <= CEBC_PROT_ALERT;
            strap_taken_q <= 1'b0;
            rd_data_q <= CEBC_READ_ZERO;
        end else begin
            ratio_q <= ratio_d;
            enable_q <= enable_d;
            prot_q <= prot_d;
            strap_taken_q <= strap_age_q[1];
            rd_data_q <= rd_data_d;
        end
    end

    // channel on-off control
    always_comb begin
        latched_off_d = latched_off_q;
        // dropping enable a re-arms a latched shutdown
        if (!channel_enable_a) begin
            latched_off_d = 1'b0;
        end
        if (trip_fast || trip_slow) begin
            latched_off_d = 1'b1; // see [R7]
        end
        if (crit && prot_q == CEBC_PROT_SHUT && strap_taken_q) begin
            latched_off_d = 1'b1; // see [R5]
        end
        gate_on_d = channel_enable_a && channel_enable_b && on_sync_q[1] && !latched_off_d;
        pg_d = gate_on_d && ok_sync_q[1];
        if (crit && prot_q != CEBC_PROT_ALERT) begin
            pg_d = 1'b0; // see [R4] [R5]
        end
        alert_d = crit || warn_sync_q[1]; // see [R3]
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latched_off_q <= 1'b0;
            gate_on_q <= 1'b0;
            power_good_output_q <= 1'b0;
            alert_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            latched_off_q <= latched_off_d;
            gate_on_q <= gate_on_d;
            power_good_output_q <= pg_d;
            alert_q <= alert_d;
            fault_q <= latched_off_d;
        end
    end

    enable_write_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R1]
        wr_en && wr_req.addr == CEBC_ADDR_ENABLE |=> enable_q == $past(wr_req.data[3:0]))
        else $error("enable write not stored");
    status_ro_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R6] [R14]
        wr_en && wr_req.addr == CEBC_ADDR_STATUS |=> $stable(enable_q) && $stable(ratio_q))
        else $error("status write changed state");
    on_status_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R2]
        rd_en && rd_addr == CEBC_ADDR_STATUS |=> rd_data_q[CEBC_ON_BIT] == $past(on_sync_q[1])
            && rd_data_q[5:1] == 5'h00)
        else $error("status read wrong");
    ratio_upper_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R11]
        rd_en && rd_addr == CEBC_ADDR_RATIO |=> rd_data_q[7:4] == 4'h0
            && rd_data_q[3:0] == $past(ratio_q))
        else $error("ratio read wrong");
    alert_only_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R3]
        crit && prot_q == CEBC_PROT_ALERT && strap_taken_q && !trip_fast && !trip_slow
            && !latched_off_q |=> alert_q && !latched_off_q)
        else $error("critical with code 00 did more than alert");
    pg_drop_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R4]
        crit && prot_q == CEBC_PROT_PG && strap_taken_q |=> alert_q && !power_good_output_q)
        else $error("critical with code 01 kept power good");
    crit_shut_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R5]
        crit && prot_q == CEBC_PROT_SHUT && strap_taken_q |=> !gate_on_q ##1 !gate_on_q)
        else $error("critical with code 10 left channel on");
    trip_off_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R7]
        trip_fast || trip_slow |=> !gate_on_q && fault_q)
        else $error("overcurrent did not turn switch off");
    prot_code_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R5]
        prot_q != CEBC_PROT_NONE)
        else $error("protection code 11 seen");
    gate_needs_all_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R1]
        gate_on_q |-> $past(channel_enable_a && channel_enable_b && on_sync_q[1]))
        else $error("gate on without both enables and on-input");
    unmapped_zero_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R14]
        rd_en && rd_addr != CEBC_ADDR_RATIO && rd_addr != CEBC_ADDR_STATUS
            && rd_addr != CEBC_ADDR_ENABLE |=> rd_data_q == CEBC_READ_ZERO)
        else $error("unmapped read not zero");
endmodule : cebc_channel_ctrl

/* verification/cebc_switch_model.sv */
// behavioural external power switch: current flows only while the gate is driven
`timescale 1ns/1ps
module cebc_switch_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // gate drive and load demand
    input wire logic gate_on_q,
    input wire logic [11:0] load_level,
    // sensed voltage across the shunt
    output logic [11:0] sense_level
);
    // one cycle of lag stands in for the shunt and comparator path
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sense_level <= 12'h000;
        end else begin
            sense_level <= gate_on_q ? load_level : 12'h000;
        end
    end
endmodule : cebc_switch_model

/* verification/tb_channel_enable_breaker_cfg.sv */
// self-checking bench for the channel enable and breaker block
`timescale 1ns/1ps
module tb_channel_enable_breaker_cfg import cebc_pkg::*;;
    logic clock, rst_b, wr_en, rd_en, on_above_thr, volt_ok;
    logic gate_on_q, power_good_output_q, alert_q, fault_q;
    cebc_wr_type wr_req;
    logic [7:0] rd_addr, rd_data_q, dac_setting, v;
    logic [1:0] prot_strap, range_sel;
    cebc_volt_type volt_crit, volt_warn;
    logic [11:0] sense_level, load_level;
    int num_errors, comparisons, cycles, f, s;
    // budget a quarter of the default lets slow trips finish inside the wait_off limit
    cebc_channel_ctrl #(.SLOW_BUDGET(20'h00FA0)) i_dut (.clock(clock), .rst_b(rst_b),
        .wr_en(wr_en), .wr_req(wr_req), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .on_above_thr(on_above_thr), .prot_strap(prot_strap),
        .volt_crit(volt_crit), .volt_warn(volt_warn), .volt_ok(volt_ok),
        .dac_setting(dac_setting), .range_sel(range_sel), .sense_level(sense_level),
        .gate_on_q(gate_on_q), .power_good_output_q(power_good_output_q),
        .alert_q(alert_q), .fault_q(fault_q));
    cebc_switch_model i_sw (.clock(clock), .rst_b(rst_b), .gate_on_q(gate_on_q),
        .load_level(load_level), .sense_level(sense_level));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic stop_test();
        $display("counts: comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_req <= '{addr: a, data: d};
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rd_data_q, exp);
    endtask : rd
    task automatic do_reset(input logic [1:0] strap);
        @(posedge clock);
        rst_b <= 1'b0;
        prot_strap <= strap;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic load(input int l);
        @(posedge clock);
        load_level <= 12'(l);
    endtask : load
    task automatic restart();
        load(0);
        // slow-trip integrator leaks slowly; let it drain before re-arming
        settle(1300);
        wr(CEBC_ADDR_ENABLE, 8'h02);
        wr(CEBC_ADDR_ENABLE, 8'h03);
        settle(6);
    endtask : restart
    task automatic wait_off(input int lim);
        int i;
        for (i = 0; i < lim && gate_on_q !== 1'b0; i++) settle(1);
        chk(8'(gate_on_q), 8'h00);
        chk(8'(fault_q), 8'h01);
    endtask : wait_off
    task automatic end_test(input string name);
        $display("test %s ended, num_errors=%0d", name, num_errors);
    endtask : end_test
    function automatic int fast_thr(input logic [1:0] rng, input logic [7:0] dac);
        int fs;
        fs = (rng == 2'h2) ? 250 : ((rng == 2'h1) ? 500 : 1000);
        return fs * (510 + 3 * int'(dac)) / 1275;
    endfunction : fast_thr
    function automatic int slow_thr(input int fast, input int code);
        return fast * 100 / (125 + 25 * code);
    endfunction : slow_thr
    initial begin
        {rst_b, wr_en, rd_en, on_above_thr, volt_ok} = 5'h00;
        {wr_req, rd_addr, dac_setting, prot_strap, range_sel} = 36'h0;
        {volt_crit, volt_warn, load_level} = 18'h0;
        void'($urandom(87));
        for (int st = 0; st < 3; st++) begin
            do_reset(2'(st));
            @(posedge clock);
            volt_ok <= 1'b1;
            on_above_thr <= 1'b1;
            wr(CEBC_ADDR_ENABLE, 8'h03);
            settle(6);
            chk({gate_on_q, power_good_output_q, alert_q}, 8'h06);
            rd(CEBC_ADDR_STATUS, {2'(st), 6'h01});
            @(posedge clock);
            // undervoltage and overvoltage both take the critical path
            volt_crit <= (st == 1) ? 3'h2 : 3'h4;
            settle(6);
            chk(8'(alert_q), 8'h01);
            chk(8'(power_good_output_q), 8'(st == 0));
            chk(8'(gate_on_q), 8'(st != 2));
            @(posedge clock);
            volt_crit <= 3'h0;
            volt_warn <= 3'h1;
            settle(6);
            chk(8'(alert_q), 8'h01);
            @(posedge clock);
            volt_warn <= 3'h0;
        end
        @(posedge clock);
        on_above_thr <= 1'b0;
        settle(6);
        chk(8'(gate_on_q), 8'h00);
        rd(CEBC_ADDR_STATUS, 8'h80);
        end_test("protection");
        do_reset(2'h0);
        rd(CEBC_ADDR_RATIO, 8'h0F);
        rd(CEBC_ADDR_ENABLE, 8'h00);
        rd(8'h31, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            wr(CEBC_ADDR_ENABLE, v);
            rd(CEBC_ADDR_ENABLE, v & 8'h0F);
            wr(CEBC_ADDR_RATIO, v | 8'hF0);
            rd(CEBC_ADDR_RATIO, v & 8'h0F);
            wr(CEBC_ADDR_STATUS, 8'hFF);
            rd(CEBC_ADDR_STATUS, 8'h00);
        end
        end_test("registers");
        @(posedge clock);
        on_above_thr <= 1'b1;
        wr(CEBC_ADDR_RATIO, 8'h03);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            // code 11 is the spare encoding that also selects the widest range
            range_sel <= 2'($urandom);
            dac_setting <= (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($urandom));
            restart();
            f = fast_thr(range_sel, dac_setting);
            load(f - 3);
            settle(6);
            chk(8'(gate_on_q), 8'h01);
            load(f + 3);
            settle(5);
            chk(8'(gate_on_q), 8'h00);
            restart();
        end
        end_test("fast trip");
        @(posedge clock);
        range_sel <= CEBC_RNG_25;
        dac_setting <= 8'h00;
        for (int c = 0; c < 4; c++) begin
            wr(CEBC_ADDR_RATIO, 8'(c));
            restart();
            s = slow_thr(100, c);
            load(s - 2);
            settle(100);
            chk(8'(gate_on_q), 8'h01);
            load(s + 10);
            settle(100);
            chk(8'(gate_on_q), 8'h01);
            wait_off(500);
            restart();
        end
        load(90);
        wait_off(150);
        end_test("slow trip");
        stop_test();
    end
endmodule : tb_channel_enable_breaker_cfg
